// File: logic/moving_average_overflow_unit.sv
// Moving average, overflow substitution and status lamp core
`include "mavg_map.svh"
module moving_average_overflow_unit
	import mavg_pkg::*;
#(
	parameter logic [23:0] FAST_CYC = 24'(`SAMPLE_FAST_MS * (`CLK_HZ / 1000)),
	parameter logic [23:0] SLOW_CYC = 24'(`SAMPLE_SLOW_MS * (`CLK_HZ / 1000)),
	parameter logic [23:0] RED_CYC = 24'(`LED_RED_MS * (`CLK_HZ / 1000)),
	parameter logic [23:0] BLINK_CYC = 24'(`LED_BLINK_MS * (`CLK_HZ / 1000))
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// Configuration write
	input wire logic cfg_write_in,
	input wire logic [3:0] cfg_code_in,
	input wire logic cfg_service_in,
	input wire logic signed [15:0] cfg_out_low_in,
	input wire logic signed [15:0] cfg_out_high_in,
	// Measuring range limits
	input wire logic signed [15:0] limit_low_in,
	input wire logic signed [15:0] limit_high_in,
	// Samples from the converter
	output logic sample_req_out,
	input wire logic sample_valid_in,
	input wire logic signed [15:0] sample_in,
	output logic sample_ready_out,
	// Results to the output stage
	output logic result_valid_out,
	output logic [15:0] result_out,
	input wire logic result_ready_in,
	// Status
	output logic overflow_out,
	output logic averaging_out,
	output logic led_red_out,
	output logic led_green_out
);
	function automatic logic [7:0] window_len(input logic [3:0] code);
		case (code)
			4'h0: window_len = `WIN_C0;
			4'h1: window_len = `WIN_C1;
			4'h2: window_len = `WIN_C2;
			4'h3: window_len = `WIN_C3;
			4'h4: window_len = `WIN_C4;
			4'h5: window_len = `WIN_C5;
			4'h6: window_len = `WIN_C6;
			4'h7: window_len = `WIN_C7;
			4'h8: window_len = `WIN_C8;
			default: window_len = `WIN_C9;
		endcase
	endfunction : window_len

	function automatic logic [23:0] period_cycles(input logic [3:0] code);
		period_cycles = (code >= `SLOW_CODE_MIN) ? SLOW_CYC : FAST_CYC;
	endfunction : period_cycles

	core_state_t state, next_state;
	led_state_t led, next_led;
	logic [3:0] avg_code, next_avg_code;
	logic ovf_service, next_ovf_service;
	logic signed [15:0] out_low, next_out_low, out_high, next_out_high;
	logic [7:0] count, next_count, ptr, next_ptr;
	logic signed [23:0] sum, next_sum;
	logic [15:0] mem [0:`WIN_MAX-1];
	logic mem_we;
	logic [15:0] mem_data;
	logic [23:0] quot, next_quot;
	logic [8:0] rem, next_rem, rem_try;
	logic [7:0] divisor, next_divisor;
	logic neg, next_neg;
	logic [4:0] step, next_step;
	logic [15:0] push_data, next_push_data;
	logic next_overflow, next_averaging, next_sample_ready;
	logic [23:0] tick_cnt, next_tick_cnt, led_cnt, next_led_cnt;
	logic next_sample_req;
	logic cfg_ok, cfg_clear, take, is_low, is_high;
	logic signed [23:0] s_ext, old_ext;
	logic [7:0] win;
	logic buf_ready;

	always_comb begin
		cfg_ok = cfg_write_in && (cfg_code_in <= `AVG_CODE_MAX);
		cfg_clear = cfg_ok && (cfg_code_in != avg_code);
		take = sample_valid_in && sample_ready_out && (state == st_idle);
		is_low = sample_in < limit_low_in;
		is_high = sample_in > limit_high_in;
		s_ext = 24'(sample_in);
		old_ext = 24'(signed'(mem[ptr]));
		win = window_len(avg_code);
		next_avg_code = cfg_ok ? cfg_code_in : avg_code;
		next_ovf_service = cfg_ok ? cfg_service_in : ovf_service;
		next_out_low = cfg_ok ? cfg_out_low_in : out_low;
		next_out_high = cfg_ok ? cfg_out_high_in : out_high;
		next_state = state;
		next_count = count;
		next_ptr = ptr;
		next_sum = sum;
		next_overflow = overflow_out;
		next_quot = quot;
		next_rem = rem;
		next_divisor = divisor;
		next_neg = neg;
		next_step = step;
		next_push_data = push_data;
		mem_we = 1'b0;
		mem_data = sample_in;
		rem_try = 9'h000;
		case (state)
			st_idle: begin
				if (take && (is_low || is_high)) begin
					next_overflow = 1'b1;
					next_count = 8'h00;
					next_ptr = 8'h00;
					next_sum = 24'h000000;
					if (ovf_service) begin
						next_push_data = is_low ? out_low : out_high;
					end else begin
						next_push_data = is_low ? limit_low_in : limit_high_in;
					end
					next_state = st_push;
				end else if (take) begin
					next_overflow = 1'b0;
					mem_we = 1'b1;
					if (count < win) begin
						next_sum = sum + s_ext;
						next_count = count + 8'h01;
					end else begin
						next_sum = sum + s_ext - old_ext;
					end
					next_ptr = (ptr == win - 8'h01) ? 8'h00 : ptr + 8'h01;
					next_neg = next_sum[23];
					next_quot = next_sum[23] ? 24'(-next_sum) : next_sum;
					next_rem = 9'h000;
					next_divisor = next_count;
					next_step = 5'h00;
					next_state = st_divide;
				end
			end
			st_divide: begin
				rem_try = {rem[7:0], quot[23]};
				next_quot = {quot[22:0], 1'b0};
				if (rem_try >= {1'b0, divisor}) begin
					next_rem = rem_try - {1'b0, divisor};
					next_quot[0] = 1'b1;
				end else begin
					next_rem = rem_try;
				end
				next_step = step + 5'h01;
				if (step == `DIV_LAST) begin
					next_push_data = neg ? 16'(-next_quot) : next_quot[15:0];
					next_state = st_push;
				end
			end
			default: begin
				if (buf_ready) begin
					next_state = st_idle;
				end
			end
		endcase
		if (cfg_clear) begin
			next_count = 8'h00;
			next_ptr = 8'h00;
			next_sum = 24'h000000;
		end
		next_averaging = next_count < window_len(next_avg_code);
		next_sample_ready = (next_state == st_idle);
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			state <= st_idle;
			avg_code <= `AVG_CODE_RESET;
			ovf_service <= 1'b0;
			out_low <= 16'h0000;
			out_high <= 16'h0000;
			count <= 8'h00;
			ptr <= 8'h00;
			sum <= 24'h000000;
			quot <= 24'h000000;
			rem <= 9'h000;
			divisor <= 8'h01;
			neg <= 1'b0;
			step <= 5'h00;
			push_data <= 16'h0000;
			overflow_out <= 1'b0;
			averaging_out <= 1'b1;
			sample_ready_out <= 1'b1;
		end else begin
			state <= next_state;
			avg_code <= next_avg_code;
			ovf_service <= next_ovf_service;
			out_low <= next_out_low;
			out_high <= next_out_high;
			count <= next_count;
			ptr <= next_ptr;
			sum <= next_sum;
			quot <= next_quot;
			rem <= next_rem;
			divisor <= next_divisor;
			neg <= next_neg;
			step <= next_step;
			push_data <= next_push_data;
			overflow_out <= next_overflow;
			averaging_out <= next_averaging;
			sample_ready_out <= next_sample_ready;
		end
	end

	always_ff @(posedge clk_in) begin
		if (mem_we) begin
			mem[ptr] <= mem_data;
		end
	end

	pair_buffer result_buf (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.in_valid_in(state == st_push),
		.in_data_in(push_data),
		.in_ready_out(buf_ready),
		.out_valid_out(result_valid_out),
		.out_data_out(result_out),
		.out_ready_in(result_ready_in)
	);

	// Sample request divider and status lamp
	always_comb begin
		next_tick_cnt = tick_cnt + 24'h000001;
		next_sample_req = 1'b0;
		if (cfg_clear) begin
			next_tick_cnt = 24'h000000;
		end else if (tick_cnt >= period_cycles(avg_code) - 24'h000001) begin
			next_tick_cnt = 24'h000000;
			next_sample_req = 1'b1;
		end
		next_led = led;
		next_led_cnt = led_cnt + 24'h000001;
		case (led)
			led_red_st: begin
				if (led_cnt >= RED_CYC - 24'h000001) begin
					next_led = led_green_st;
					next_led_cnt = 24'h000000;
				end
			end
			led_green_st: begin
				next_led_cnt = 24'h000000;
				if (cfg_ok) begin
					next_led = led_off_st;
				end
			end
			default: begin
				if (cfg_ok) begin
					next_led_cnt = 24'h000000;
				end else if (led_cnt >= BLINK_CYC - 24'h000001) begin
					next_led = led_green_st;
					next_led_cnt = 24'h000000;
				end
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			tick_cnt <= 24'h000000;
			sample_req_out <= 1'b0;
			led <= led_red_st;
			led_cnt <= 24'h000000;
			led_red_out <= 1'b1;
			led_green_out <= 1'b0;
		end else begin
			tick_cnt <= next_tick_cnt;
			sample_req_out <= next_sample_req;
			led <= next_led;
			led_cnt <= next_led_cnt;
			led_red_out <= (next_led == led_red_st);
			led_green_out <= (next_led == led_green_st);
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	sequence s_take_ok;
		take && !is_low && !is_high;
	endsequence
	sequence s_take_ovf;
		take && (is_low || is_high);
	endsequence

	a_red_once: assert property (!$past(led_red_out) |-> !led_red_out)
		else $error("lamp went red again");
	a_blink_off: assert property (cfg_ok && led == led_green_st |=> !led_green_out && !led_red_out)
		else $error("write did not blink lamp");
	a_blink_bound: assert property (led == led_off_st |-> led_cnt < BLINK_CYC)
		else $error("blink too long");
	a_partial_count: assert property ((s_take_ok and (count < win && !cfg_clear)) |=> count == $past(count) + 8'h01)
		else $error("partial count did not grow");
	a_div_steps: assert property (s_take_ok |=> (state == st_divide && step == 5'h00) ##23 (state == st_divide && step == `DIV_LAST) ##1 state == st_push)
		else $error("mean not produced in 24 cycles");
	a_ovf_restart: assert property ((s_take_ovf and !cfg_clear) |=> overflow_out && count == 8'h00 && sum == 24'h000000)
		else $error("overflow did not restart");
	a_window_slide: assert property ((s_take_ok and (count == win && !cfg_clear)) |=> count == $past(count))
		else $error("full window changed size");
	a_reset_code: assert property ($past(!rst_b_in) |-> avg_code == `AVG_CODE_RESET)
		else $error("wrong default averaging code");
	a_tick_bound: assert property (tick_cnt < period_cycles(avg_code) || $past(cfg_ok))
		else $error("sample period overrun");
	a_window_len: assert property (count <= window_len(avg_code))
		else $error("count beyond window");
	a_ovf_subst: assert property ((s_take_ovf and (ovf_service && is_low)) |=> state == st_push && push_data == $past(out_low))
		else $error("lower substitute not applied");
	a_avg_flag: assert property (averaging_out == (count < window_len(avg_code)))
		else $error("averaging flag wrong");
	a_code_clear: assert property (cfg_clear |=> count == 8'h00 && sum == 24'h000000)
		else $error("code change did not clear");
	a_ovf_clear: assert property ((s_take_ok and overflow_out) |=> !overflow_out)
		else $error("overflow not cleared");
endmodule : moving_average_overflow_unit

// File: logic/mavg_map.svh
// Constants for the moving average and overflow unit
`ifndef MAVG_MAP_SVH
`define MAVG_MAP_SVH
`define CLK_HZ 20000000
`define SAMPLE_FAST_MS 30
`define SAMPLE_SLOW_MS 500
`define LED_RED_MS 500
`define LED_BLINK_MS 100
`define AVG_CODE_RESET 4'h4
`define AVG_CODE_MAX 4'h9
`define SLOW_CODE_MIN 4'h7
`define WIN_MAX 172
`define DIV_LAST 5'h17
`define WIN_C0 8'h06
`define WIN_C1 8'h0d
`define WIN_C2 8'h14
`define WIN_C3 8'h1b
`define WIN_C4 8'h22
`define WIN_C5 8'h67
`define WIN_C6 8'hac
`define WIN_C7 8'h14
`define WIN_C8 8'h1e
`define WIN_C9 8'h28
`endif

// File: logic/mavg_pkg.sv
// Types shared by the moving average and overflow unit
package mavg_pkg;
	typedef enum logic [1:0] {st_idle, st_divide, st_push} core_state_t;
	typedef enum logic [1:0] {led_red_st, led_green_st, led_off_st} led_state_t;
endpackage : mavg_pkg

// File: logic/pair_buffer.sv
// Two-entry result buffer with valid and ready on both sides
module pair_buffer (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// Filling side
	input wire logic in_valid_in,
	input wire logic [15:0] in_data_in,
	output logic in_ready_out,
	// Draining side
	output logic out_valid_out,
	output logic [15:0] out_data_out,
	input wire logic out_ready_in
);
	logic [15:0] slot [0:1];
	logic [15:0] next_slot [0:1];
	logic rd_idx, next_rd_idx, wr_idx, next_wr_idx;
	logic [1:0] fill, next_fill;
	logic push, pop;

	always_comb begin
		push = in_valid_in && in_ready_out;
		pop = out_valid_out && out_ready_in;
		next_slot[0] = slot[0];
		next_slot[1] = slot[1];
		next_wr_idx = wr_idx;
		next_rd_idx = rd_idx;
		next_fill = fill;
		if (push) begin
			next_slot[wr_idx] = in_data_in;
			next_wr_idx = !wr_idx;
		end
		if (pop) begin
			next_rd_idx = !rd_idx;
		end
		if (push && !pop) begin
			next_fill = fill + 2'h1;
		end else if (pop && !push) begin
			next_fill = fill - 2'h1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			slot[0] <= 16'h0000;
			slot[1] <= 16'h0000;
			rd_idx <= 1'b0;
			wr_idx <= 1'b0;
			fill <= 2'h0;
			in_ready_out <= 1'b1;
			out_valid_out <= 1'b0;
			out_data_out <= 16'h0000;
		end else begin
			slot[0] <= next_slot[0];
			slot[1] <= next_slot[1];
			rd_idx <= next_rd_idx;
			wr_idx <= next_wr_idx;
			fill <= next_fill;
			in_ready_out <= (next_fill != 2'h2);
			out_valid_out <= (next_fill != 2'h0);
			out_data_out <= next_slot[next_rd_idx];
		end
	end
endmodule : pair_buffer

// File: tb/mavg_far_side.sv
// Converter and output stage model facing the averaging core
module mavg_far_side (
	// Clock
	input wire logic clk_in,
	// Converter side
	input wire logic take_ready_in,
	output logic sample_valid_out,
	output logic signed [15:0] sample_out,
	// Output stage side
	input wire logic stall_in,
	input wire logic result_valid_in,
	input wire logic [15:0] result_in,
	output logic result_ready_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic signed [15:0] pend[$];
	logic [15:0] got[$];
	bit taken;
	initial begin
		sample_valid_out = 1'h0;
		sample_out = 16'h0000;
		result_ready_out = 1'h0;
		forever begin
			@(posedge clk_in);
			taken = sample_valid_out && take_ready_in;
			if (result_valid_in && result_ready_out)
				got.push_back(result_in);
			#1;
			// Released data line toggles so no stale value lingers
			if (taken) begin
				void'(pend.pop_front());
				sample_valid_out = 1'h0;
				sample_out = ~sample_out;
			end else if (!sample_valid_out && pend.size() != 0) begin
				sample_valid_out = 1'h1;
				sample_out = pend[0];
			end
			result_ready_out = !stall_in && ($urandom_range(3) != 0);
		end
	end
endmodule : mavg_far_side

// File: tb/moving_average_overflow_unit_bench.sv
// Self-checking bench of the moving average and overflow unit
module moving_average_overflow_unit_bench;
	import mavg_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int FAST = 32'h28;
	localparam int SLOW = 32'h50;
	localparam int RED = 32'h14;
	localparam int BLINK = 32'h0a;
	logic clk_in, rst_b_in, cfg_write_in, cfg_service_in, stall;
	logic [3:0] cfg_code_in;
	logic signed [15:0] cfg_out_low_in, cfg_out_high_in, limit_low_in, limit_high_in, sample_in;
	logic sample_req_out, sample_valid_in, sample_ready_out, result_valid_out, result_ready_in;
	logic [15:0] result_out;
	logic overflow_out, averaging_out, led_red_out, led_green_out;
	int n_errors, cmp_count, code, olo, ohi, lo, hi, ovf, c;
	bit svc;
	int hist[$];
	int exq[$];

	moving_average_overflow_unit #(.FAST_CYC(24'h28), .SLOW_CYC(24'h50), .RED_CYC(24'h14),
		.BLINK_CYC(24'h0a)) dut_u (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.cfg_write_in(cfg_write_in), .cfg_code_in(cfg_code_in), .cfg_service_in(cfg_service_in),
		.cfg_out_low_in(cfg_out_low_in), .cfg_out_high_in(cfg_out_high_in),
		.limit_low_in(limit_low_in), .limit_high_in(limit_high_in),
		.sample_req_out(sample_req_out), .sample_valid_in(sample_valid_in), .sample_in(sample_in),
		.sample_ready_out(sample_ready_out), .result_valid_out(result_valid_out),
		.result_out(result_out), .result_ready_in(result_ready_in), .overflow_out(overflow_out),
		.averaging_out(averaging_out), .led_red_out(led_red_out), .led_green_out(led_green_out));

	mavg_far_side conv_u (.clk_in(clk_in), .take_ready_in(sample_ready_out),
		.sample_valid_out(sample_valid_in), .sample_out(sample_in), .stall_in(stall),
		.result_valid_in(result_valid_out), .result_in(result_out),
		.result_ready_out(result_ready_in));

	initial begin
		clk_in = 1'h0;
		forever #25 clk_in = ~clk_in;
	end

	function automatic int wlen(input int k);
		int t[10] = '{6, 13, 20, 27, 34, 103, 172, 20, 30, 40};
		return t[k];
	endfunction : wlen

	function automatic int rnd();
		return int'($urandom_range(1998)) - 999;
	endfunction : rnd

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : tally_and_finish

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic step();
		@(posedge clk_in);
		#1;
	endtask : step

	task automatic until_green();
		for (int w = 0; w < RED + BLINK + 5 && led_green_out !== 1'h1; w++)
			step();
		check(led_green_out, 1);
	endtask : until_green

	// Expected result of one sample, worked out from the window rules
	task automatic feed(input int s);
		int sum;
		sum = 0;
		ovf = (s < lo || s > hi);
		if (ovf) begin
			hist.delete();
			exq.push_back(svc ? (s < lo ? olo : ohi) : (s < lo ? lo : hi));
		end else begin
			hist.push_back(s);
			if (hist.size() > wlen(code))
				void'(hist.pop_front());
			foreach (hist[i])
				sum += hist[i];
			exq.push_back(sum / hist.size());
		end
		conv_u.pend.push_back(16'(s));
	endtask : feed

	task automatic drain(input int n);
		repeat (n) begin
			for (int w = 0; w < 400 && conv_u.got.size() == 0; w++)
				step();
			if (conv_u.got.size() == 0) begin
				n_errors++;
				tally_and_finish();
			end
			check(conv_u.got.pop_front(), 16'(exq.pop_front()));
		end
	endtask : drain

	task automatic one(input int s);
		feed(s);
		drain(1);
		check(overflow_out, 16'(ovf));
		check(averaging_out, 16'(hist.size() < wlen(code)));
	endtask : one

	task automatic cfg(input logic [3:0] k, input bit s, input int l, input int h);
		cfg_code_in = k;
		cfg_service_in = s;
		cfg_out_low_in = 16'(l);
		cfg_out_high_in = 16'(h);
		cfg_write_in = 1'h1;
		step();
		cfg_write_in = 1'h0;
		step();
		check({led_red_out, led_green_out}, 16'(k > 9 ? 1 : 0));
		if (k <= 9) begin
			if (k != code)
				hist.delete();
			code = k;
			svc = s;
			olo = l;
			ohi = h;
		end
		until_green();
	endtask : cfg

	task automatic period(input int exp);
		int t;
		for (int w = 0; w < 200 && sample_req_out !== 1'h1; w++)
			step();
		t = 0;
		do begin
			step();
			t++;
		end while (sample_req_out !== 1'h1 && t < 200);
		check(16'(t), 16'(exp));
	endtask : period

	initial begin
		void'($urandom(96));
		rst_b_in = 1'h0;
		stall = 1'h0;
		cfg_write_in = 1'h0;
		cfg_code_in = 4'h0;
		cfg_service_in = 1'h0;
		cfg_out_low_in = 16'h0000;
		cfg_out_high_in = 16'h0000;
		lo = -32'h3e8;
		hi = 32'h3e8;
		limit_low_in = 16'(lo);
		limit_high_in = 16'(hi);
		code = 4;
		repeat (3) step();
		check({led_red_out, led_green_out, averaging_out}, 16'h5);
		rst_b_in = 1'h1;
		until_green();
		repeat (36) one(rnd());
		one(-32'h5dc);
		one(32'h5dc);
		one(32'h7);
		cfg(4'h4, 1'h1, 32'h123, -32'h12c);
		one(-32'h7d0);
		one(32'h7d0);
		cfg(4'ha, 1'h0, 0, 0);
		one(-32'h7d0);
		// Output stage stalls until both buffer entries and the core are full
		stall = 1'h1;
		repeat (4) feed(rnd());
		repeat (150) step();
		check(sample_ready_out, 0);
		check(16'(conv_u.pend.size()), 1);
		stall = 1'h0;
		drain(4);
		for (c = 0; c < 10; c++) begin
			cfg(4'(c), 1'($urandom_range(1)), rnd(), rnd());
			period(c < 7 ? FAST : SLOW);
			repeat (wlen(c) + 2) one(rnd());
		end
		tally_and_finish();
	end
endmodule : moving_average_overflow_unit_bench
